// >>> rtl/cmp_pkg.sv
// Constants shared by the triple comparator control logic.
// Assumes a 16-bit register port with word addresses on a 4-bit address.
package cmp_pkg;

  // ********************************************************************
  // Geometry
  // ********************************************************************
  localparam int NUM_CH = 3;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ********************************************************************
  // Register offsets (word addresses)
  // ********************************************************************
  localparam logic [ADDR_W-1:0] CTRL_BASE_OFF = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFF    = 4'h3;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF  = 4'h4;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF  = 4'h5;

  // ********************************************************************
  // Channel control register fields
  // ********************************************************************
  localparam int CTRL_ON_BIT     = 15;
  localparam int CTRL_DRIVE_BIT  = 14;
  localparam int CTRL_INVERT_BIT = 13;
  localparam int CTRL_EVENT_BIT  = 9;
  localparam int CTRL_RESULT_BIT = 8;
  localparam int CTRL_EDGE_LO    = 6;
  localparam int CTRL_NONINV_BIT = 4;
  localparam int CTRL_INVSEL_LO  = 0;

  // ********************************************************************
  // Module status register fields
  // ********************************************************************
  localparam int STAT_IDLE_BIT  = 15;
  localparam int STAT_EVENT_LO  = 8;
  localparam int STAT_RESULT_LO = 0;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [1:0] EDGE_RESET   = 2'h0;
  localparam logic [1:0] INVSEL_RESET = 2'h0;
  localparam logic       BIT_RESET    = 1'b0;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;

  // ********************************************************************
  // Encodings
  // ********************************************************************
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY  = 2'b11
  } edge_sel_e;

  typedef enum logic [1:0] {
    INV_PIN_B     = 2'b00,
    INV_PIN_C     = 2'b01,
    INV_PIN_D     = 2'b10,
    INV_HALF_BGAP = 2'b11
  } inv_sel_e;

endpackage

// >>> rtl/cmp_chan_if.sv
// Link between the register block and one comparator channel.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface cmp_chan_if;
  logic       on;
  logic       drive;
  logic       invert;
  logic [1:0] edge_sel;
  logic       clear_event;
  logic       raw;
  logic       result;
  logic       event_flag;
  logic       trigger;
  logic       pin;

  modport regs (output on, output drive, output invert, output edge_sel,
                output clear_event, output raw,
                input result, input event_flag, input trigger, input pin);
  modport chan (input on, input drive, input invert, input edge_sel,
                input clear_event, input raw,
                output result, output event_flag, output trigger, output pin);
endinterface

// >>> rtl/cmp_channel.sv
// One comparator channel: output polarity, edge detect, event latch.
// Assumes the raw comparison is already synchronous to clk.
`timescale 1ns/10ps
module cmp_channel (
  input wire logic clk,
  input wire logic rst_b,
  cmp_chan_if.chan ch
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic prev_result;
    logic event_latched;
  } chan_state_s;

  chan_state_s st_reg;
  chan_state_s st_next;
  logic        result;
  logic        edge_hit;
  logic        trig;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    result = ch.on & (ch.raw ^ ch.invert);
    case (cmp_pkg::edge_sel_e'(ch.edge_sel))
      cmp_pkg::EDGE_RISE: edge_hit = result & ~st_reg.prev_result;
      cmp_pkg::EDGE_FALL: edge_hit = ~result & st_reg.prev_result;
      cmp_pkg::EDGE_ANY:  edge_hit = result ^ st_reg.prev_result;
      cmp_pkg::EDGE_NONE: edge_hit = 1'b0;
      default:            edge_hit = 1'b0;
    endcase
    // Blocked while latched; a clear in the same cycle reopens it
    trig = edge_hit & (~st_reg.event_latched | ch.clear_event);
    st_next = st_reg;
    st_next.prev_result = result;
    st_next.event_latched = trig | (st_reg.event_latched & ~ch.clear_event);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_next_reg_update: st_reg <= st_next;
    end
  end

  assign ch.result     = result;
  assign ch.event_flag = st_reg.event_latched;
  assign ch.trigger    = trig;
  // Unsynchronised path to the pad, not delayed by a flip-flop
  assign ch.pin        = ch.drive & result;

endmodule

// >>> rtl/triple_comparator_control.sv
// Register block and channel array of the triple comparator control.
// Assumes analog cores return a compare bit and follow the source selects.
//
// Functional notes
// - Three channels, own control, shared status
// - Channel off forces output to zero
// - Pin carries result only when drive enabled
// - Non-inverting source bit picks reference or A
// - Inverting select picks B, C, D, half-bandgap
// - Idle suppress bit blocks interrupts in idle
// - Status bits 8-10 mirror channel events
// - Status bits 0-2 mirror channel results
// - Unimplemented bits ignore writes, read zero
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module triple_comparator_control #(
  parameter int CHANNELS = cmp_pkg::NUM_CH
) (
  input  wire  logic                       clk,
  input  wire  logic                       rst_b,
  input  wire  logic [cmp_pkg::ADDR_W-1:0] addr,
  input  wire  logic [cmp_pkg::DATA_W-1:0] wdata,
  input  wire  logic                       wr_en,
  input  wire  logic                       rd_en,
  output logic       [cmp_pkg::DATA_W-1:0] rdata,
  input  wire  logic                       idle_mode,
  input  wire  logic [CHANNELS-1:0]        cmp_raw,
  output logic       [CHANNELS-1:0]        channel_on,
  output logic       [CHANNELS-1:0]        noninv_source_select,
  output logic       [2*CHANNELS-1:0]      inv_source_select,
  output logic       [CHANNELS-1:0]        result_pin,
  output logic       [CHANNELS-1:0]        result_pin_oe_b,
  output logic                             irq
);

  // ********************************************************************
  // Elaboration check
  // ********************************************************************
  // Status layout holds exactly three channels
  if (CHANNELS != cmp_pkg::NUM_CH) begin : g_bad_channels
    $error("CHANNELS must equal the status register layout width");
  end

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [CHANNELS-1:0]      on;
    logic [CHANNELS-1:0]      drive;
    logic [CHANNELS-1:0]      invert;
    logic [CHANNELS-1:0]      noninv;
    logic [CHANNELS-1:0][1:0] edge_sel;
    logic [CHANNELS-1:0][1:0] inv_sel;
    logic                     idle_suppress;
    logic [CHANNELS-1:0]      irq_stat;
    logic [CHANNELS-1:0]      irq_mask;
    logic [cmp_pkg::DATA_W-1:0] rdata;
  } top_state_s;

  top_state_s          st_reg;
  top_state_s          st_next;
  logic [CHANNELS-1:0] ch_result;
  logic [CHANNELS-1:0] ch_event;
  logic [CHANNELS-1:0] ch_trigger;
  logic [CHANNELS-1:0] ch_pin;
  logic [CHANNELS-1:0] ctrl_hit;
  logic [CHANNELS-1:0] clear_event;
  logic                irq_block;

  // ********************************************************************
  // Channels
  // ********************************************************************
  cmp_chan_if ch_if[CHANNELS] ();

  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    assign ch_if[g].on          = st_reg.on[g];
    assign ch_if[g].drive       = st_reg.drive[g];
    assign ch_if[g].invert      = st_reg.invert[g];
    assign ch_if[g].edge_sel    = st_reg.edge_sel[g];
    assign ch_if[g].clear_event = clear_event[g];
    assign ch_if[g].raw         = cmp_raw[g];
    assign ch_result[g]         = ch_if[g].result;
    assign ch_event[g]          = ch_if[g].event_flag;
    assign ch_trigger[g]        = ch_if[g].trigger;
    assign ch_pin[g]            = ch_if[g].pin;

    cmp_channel u_channel (
      .clk   (clk),
      .rst_b (rst_b),
      .ch    (ch_if[g].chan)
    );
  end

  // ********************************************************************
  // Write decode
  // ********************************************************************
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      ctrl_hit[i] = wr_en &&
                    (addr == cmp_pkg::CTRL_BASE_OFF + cmp_pkg::ADDR_W'(i));
      // Event bit is cleared by writing zero; a one leaves it alone
      clear_event[i] = ctrl_hit[i] && !wdata[cmp_pkg::CTRL_EVENT_BIT];
    end
  end

  assign irq_block = st_reg.idle_suppress & idle_mode;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    st_next = st_reg;
    // Only named fields are stored; other bits are dropped
    for (int i = 0; i < CHANNELS; i++) begin
      if (ctrl_hit[i]) begin
        st_next.on[i]       = wdata[cmp_pkg::CTRL_ON_BIT];
        st_next.drive[i]    = wdata[cmp_pkg::CTRL_DRIVE_BIT];
        st_next.invert[i]   = wdata[cmp_pkg::CTRL_INVERT_BIT];
        st_next.noninv[i]   = wdata[cmp_pkg::CTRL_NONINV_BIT];
        st_next.edge_sel[i] = wdata[cmp_pkg::CTRL_EDGE_LO +: 2];
        st_next.inv_sel[i]  = wdata[cmp_pkg::CTRL_INVSEL_LO +: 2];
      end
    end
    if (wr_en && addr == cmp_pkg::STATUS_OFF) begin
      st_next.idle_suppress = wdata[cmp_pkg::STAT_IDLE_BIT];
    end
    if (wr_en && addr == cmp_pkg::IRQ_MASK_OFF) begin
      st_next.irq_mask = wdata[CHANNELS-1:0];
    end
    // Write-one-to-clear; a new trigger in the same cycle wins
    if (wr_en && addr == cmp_pkg::IRQ_STAT_OFF) begin
      st_next.irq_stat = st_reg.irq_stat & ~wdata[CHANNELS-1:0];
    end
    st_next.irq_stat = st_next.irq_stat | (ch_trigger & {CHANNELS{~irq_block}});

    // Read data stands only in the cycle after the read strobe
    st_next.rdata = cmp_pkg::WORD_RESET;
    if (rd_en) begin
      if (addr == cmp_pkg::STATUS_OFF) begin
        st_next.rdata[cmp_pkg::STAT_IDLE_BIT] = st_reg.idle_suppress;
        st_next.rdata[cmp_pkg::STAT_EVENT_LO +: CHANNELS] = ch_event;
        st_next.rdata[cmp_pkg::STAT_RESULT_LO +: CHANNELS] = ch_result;
      end else if (addr == cmp_pkg::IRQ_STAT_OFF) begin
        st_next.rdata[CHANNELS-1:0] = st_reg.irq_stat;
      end else if (addr == cmp_pkg::IRQ_MASK_OFF) begin
        st_next.rdata[CHANNELS-1:0] = st_reg.irq_mask;
      end else begin
        for (int i = 0; i < CHANNELS; i++) begin
          if (addr == cmp_pkg::CTRL_BASE_OFF + cmp_pkg::ADDR_W'(i)) begin
            st_next.rdata[cmp_pkg::CTRL_ON_BIT]     = st_reg.on[i];
            st_next.rdata[cmp_pkg::CTRL_DRIVE_BIT]  = st_reg.drive[i];
            st_next.rdata[cmp_pkg::CTRL_INVERT_BIT] = st_reg.invert[i];
            st_next.rdata[cmp_pkg::CTRL_EVENT_BIT]  = ch_event[i];
            st_next.rdata[cmp_pkg::CTRL_RESULT_BIT] = ch_result[i];
            st_next.rdata[cmp_pkg::CTRL_EDGE_LO +: 2] = st_reg.edge_sel[i];
            st_next.rdata[cmp_pkg::CTRL_NONINV_BIT] = st_reg.noninv[i];
            st_next.rdata[cmp_pkg::CTRL_INVSEL_LO +: 2] = st_reg.inv_sel[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign rdata                = st_reg.rdata;
  assign channel_on           = st_reg.on;
  assign noninv_source_select = st_reg.noninv;
  assign inv_source_select    = st_reg.inv_sel;
  assign result_pin           = ch_pin;
  assign result_pin_oe_b      = ~st_reg.drive;
  assign irq                  = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule

// >>> sim/cmp_cores.sv
// Behavioural model of the three analog comparator cores.
// Assumes pin levels come from the bench as 8-bit codes.
`timescale 1ns/10ps
module cmp_cores #(
  parameter logic [7:0] PROG_REF  = 8'hc8,
  parameter logic [7:0] HALF_BGAP = 8'h40
) (
  input  wire logic        clk,
  input  wire logic [2:0]  channel_on,
  input  wire logic [2:0]  noninv_source_select,
  input  wire logic [5:0]  inv_source_select,
  input  wire logic [23:0] in_a,
  input  wire logic [23:0] in_b,
  input  wire logic [23:0] in_c,
  input  wire logic [23:0] in_d,
  output logic      [2:0]  cmp_raw
);
  // ********
  // Cores
  // ********
  logic [7:0] vp;
  logic [7:0] vm;
  // Registered, so the design sees a clean synchronous bit
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      vp = noninv_source_select[i] ? PROG_REF : in_a[8*i+:8];
      case (inv_source_select[2*i+:2])
        2'h0: vm = in_b[8*i+:8];
        2'h1: vm = in_c[8*i+:8];
        2'h2: vm = in_d[8*i+:8];
        default: vm = HALF_BGAP;
      endcase
      cmp_raw[i] <= channel_on[i] && (vp > vm);
    end
  end
endmodule

// >>> sim/cmp_ctl_props.sv
// Concurrent checks on the top-level ports of the comparator control.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/10ps
module cmp_ctl_props #(
  parameter int CHANNELS = 3
) (
  input wire logic                       clk,
  input wire logic                       rst_b,
  input wire logic [cmp_pkg::ADDR_W-1:0] addr,
  input wire logic [cmp_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr_en,
  input wire logic                       rd_en,
  input wire logic [cmp_pkg::DATA_W-1:0] rdata,
  input wire logic                       idle_mode,
  input wire logic [CHANNELS-1:0]        cmp_raw,
  input wire logic [CHANNELS-1:0]        channel_on,
  input wire logic [CHANNELS-1:0]        noninv_source_select,
  input wire logic [2*CHANNELS-1:0]      inv_source_select,
  input wire logic [CHANNELS-1:0]        result_pin,
  input wire logic [CHANNELS-1:0]        result_pin_oe_b,
  input wire logic                       irq
);
  // ********
  // Checks
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rd_idle; !$past(rd_en) |-> rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_pin_gate; (result_pin & (result_pin_oe_b | ~channel_on)) == '0; endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin driven while gated");
  property p_ch0_cfg;
    wr_en && addr == 4'h0 |=> {channel_on[0], noninv_source_select[0], inv_source_select[1:0]}
      == $past({wdata[15], wdata[4], wdata[1:0]});
  endproperty
  a_ch0_cfg: assert property (p_ch0_cfg) else $error("channel 0 setup lost");
  property p_ch1_src; wr_en && addr == 4'h1 |=> noninv_source_select[1] == $past(wdata[4]);
  endproperty
  a_ch1_src: assert property (p_ch1_src) else $error("channel 1 source lost");
  property p_ch2_sel; wr_en && addr == 4'h2 |=> inv_source_select[5:4] == $past(wdata[1:0]);
  endproperty
  a_ch2_sel: assert property (p_ch2_sel) else $error("channel 2 select lost");
  property p_drive; wr_en && addr == 4'h1 |=> result_pin_oe_b[1] == !$past(wdata[14]);
  endproperty
  a_drive: assert property (p_drive) else $error("pin enable wrong");
  property p_ctrl_zero; rd_en && addr < 4'h3 |=> (rdata & 16'h1c2c) == 16'h0000; endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control hole nonzero");
  property p_stat_zero; rd_en && addr == 4'h3 |=> (rdata & 16'h78f8) == 16'h0000;
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status hole nonzero");
  property p_unmapped; rd_en && addr > 4'h5 |=> rdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
endmodule

bind triple_comparator_control cmp_ctl_props #(.CHANNELS(CHANNELS)) u_props (
  .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .idle_mode(idle_mode), .cmp_raw(cmp_raw), .channel_on(channel_on),
  .noninv_source_select(noninv_source_select), .inv_source_select(inv_source_select),
  .result_pin(result_pin), .result_pin_oe_b(result_pin_oe_b), .irq(irq));

// >>> sim/triple_comparator_control_tb.sv
// Self-checking bench for the triple comparator control.
// Assumes cmp_cores stands in for the analog side.
`timescale 1ns/10ps
module triple_comparator_control_tb;
  // ********
  // Harness
  // ********
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        idle_mode = 1'b0;
  logic [23:0] in_a = 24'h64_6428;
  logic [23:0] in_b = 24'hfa_fafa;
  logic [23:0] in_c = 24'hfa_fafa;
  logic [23:0] in_d = 24'hfa_fafa;
  logic [15:0] rdata;
  logic [2:0]  cmp_raw, channel_on, noninv_source_select, result_pin, result_pin_oe_b;
  logic [5:0]  inv_source_select;
  logic        irq;
  int          err_total = 0;
  int          num_checks = 0;
  triple_comparator_control dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .idle_mode(idle_mode), .cmp_raw(cmp_raw),
    .channel_on(channel_on), .noninv_source_select(noninv_source_select),
    .inv_source_select(inv_source_select), .result_pin(result_pin),
    .result_pin_oe_b(result_pin_oe_b), .irq(irq));
  cmp_cores cores (.clk(clk), .channel_on(channel_on), .noninv_source_select(noninv_source_select),
    .inv_source_select(inv_source_select), .in_a(in_a), .in_b(in_b), .in_c(in_c),
    .in_d(in_d), .cmp_raw(cmp_raw));
  initial forever #25 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd(i[3:0], 16'h0000, "reset word");
    chk("reset pin enables", {13'h0, result_pin_oe_b}, 16'h0007);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000, "unmapped");
    wr(4'h0, 16'h7fff);
    rd(4'h0, 16'h60d3, "control holes");
    chk("pin while off", {13'h0, result_pin}, 16'h0000);
    wr(4'h0, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_route();
    logic [15:0] c;
    logic        e;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      in_b[7:0] <= (k[1:0] == 2'h0) ? 8'h14 : 8'hfa;
      in_c[7:0] <= (k[1:0] == 2'h1) ? 8'h14 : 8'hfa;
      in_d[7:0] <= (k[1:0] == 2'h2) ? 8'h14 : 8'hfa;
      c = {2'b11, k[2], 8'h00, k[3], 2'b00, k[1:0]};
      e = (k[1:0] != 2'h3 || k[3]) ^ k[2];
      wr(4'h0, c);
      settle();
      rd(4'h3, {15'h0, e}, "status result");
      chk("result pin", {15'h0, result_pin[0]}, {15'h0, e});
      rd(4'h0, c | {7'h0, e, 8'h00}, "control readback");
    end
    wr(4'h0, 16'h4010);
    settle();
    rd(4'h3, 16'h0000, "off result");
    chk("off pin", {15'h0, result_pin[0]}, 16'h0000);
    wr(4'h0, 16'h8013);
    settle();
    rd(4'h3, 16'h0001, "undriven result");
    chk("undriven pin", {14'h0, result_pin[0], result_pin_oe_b[0]}, 16'h0001);
    wr(4'h0, 16'h0000);
    $display("test route done");
  endtask
  task automatic t_events();
    wr(4'h5, 16'h0007);
    for (int e = 0; e < 4; e++) begin
      wr(4'h1, {8'h80, e[1:0], 6'h00});
      wr(4'h4, 16'h0007);
      settle();
      @(posedge clk) in_b[15:8] <= 8'h32;
      settle();
      rd(4'h3, {6'h0, e[0], 7'h0, 2'b10}, "status rise");
      chk("irq rise", {15'h0, irq}, {15'h0, e[0]});
      wr(4'h4, 16'h0007);
      @(posedge clk) in_b[15:8] <= 8'hfa;
      settle();
      rd(4'h3, {6'h0, e != 0, 9'h0}, "status fall");
      chk("irq fall", {15'h0, irq}, {15'h0, e == 2});
      wr(4'h1, 16'h0000);
      wr(4'h4, 16'h0007);
    end
    $display("test events done");
  endtask
  task automatic t_idle();
    @(posedge clk) idle_mode <= 1'b1;
    wr(4'h3, 16'h8000);
    wr(4'h2, 16'h80c0);
    wr(4'h4, 16'h0007);
    @(posedge clk) in_b[23:16] <= 8'h32;
    settle();
    rd(4'h3, 16'h8404, "idle status");
    rd(4'h4, 16'h0000, "idle irq status");
    chk("idle irq", {15'h0, irq}, 16'h0000);
    @(posedge clk) idle_mode <= 1'b0;
    wr(4'h2, 16'h80c0);
    @(posedge clk) in_b[23:16] <= 8'hfa;
    settle();
    rd(4'h4, 16'h0004, "irq status");
    chk("irq on", {15'h0, irq}, 16'h0001);
    wr(4'h5, 16'h0000);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    wr(4'h4, 16'h0004);
    rd(4'h4, 16'h0000, "irq cleared");
    $display("test idle done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_route();
    t_events();
    t_idle();
    final_report();
  end
endmodule
